// [hw/tfsr_pkg.sv]
// Constants and types for the tape formatter status and read port
// ------------------------------------------------------------------
// How it works
// R01: Refuse non-clear commands while formatter or selected transport busy; flag and pulse.
// R02: Also refuse reverse at load point, write without ring, external reject.
// R03: Nine-track indicator low for nine-track unit, high for seven-track.
// R04: Recording-method indicator low for NRZ unit, high for phase-encoded unit.
// R05: Head-type indicator low for single gap, high for dual gap.
// R06: Speed indicator low for low speed unit, high for high speed.
// R07: Latch timing error low when a character is not moved in time.
// R08: Phase-encoded: check error on correctable, uncorrectable, preamble, skew, dropout.
// R09: Phase-encoded read: vertical parity without dropout pulses check line during strobe.
// R10: NRZ: check error on longitudinal or vertical check failure.
// R11: File-mark status low once a file mark is detected.
// R12: Ready status low when selected transport is ready.
// R13: Rewind status low while rewinding and until transport ready again.
// R14: Write-protect status low when no write ring fitted.
// R15: Load-point status low while at beginning of tape.
// R16: Write-mode indicator low while writing a record.
// R17: Read-mode indicator low while reading.
// R18: Phase-encoded: identification status low on burst detected leaving load point.
// R19: Corrected-error low on corrected single-track error; NRZ presents zero.
// R20: Read data buffered, changes just before strobe, steady until next strobe.
// R21: Transfer request rises at strobe end; acknowledge must come before next strobe.
// R22: Adaptor may flag over-length records from extra strobes.
// R23: Latched status persists until next accepted command or deselection.
// R24: Transfer request cleared at leading edge of acknowledge.
// ------------------------------------------------------------------
package tfsr_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int STROBE_NS = 100;
    localparam int STROBE_CYCLES = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int STROBE_W = 4;
    localparam logic [STROBE_W-1:0] STROBE_LEN = STROBE_CYCLES[STROBE_W-1:0];
    localparam logic [STROBE_W-1:0] STROBE_ZERO = 4'h0;
    localparam int DATA_W = 9;
    localparam logic [DATA_W-1:0] DATA_RESET = 9'h000;
    localparam logic ACT = 1'b0;
    localparam logic IDLE = 1'b1;

    typedef enum logic [1:0] {
        TFSR_CMD_CLEAR = 2'h0,
        TFSR_CMD_READ = 2'h1,
        TFSR_CMD_WRITE = 2'h2,
        TFSR_CMD_OTHER = 2'h3
    } tfsr_cmd_type;

    typedef enum logic [1:0] {
        TFSR_RD_IDLE = 2'h0,
        TFSR_RD_LEAD = 2'h1,
        TFSR_RD_STROBE = 2'h3
    } tfsr_rd_state_type;

    function automatic logic tfsr_lvl(input logic active);
        return active ? ACT : IDLE;
    endfunction : tfsr_lvl
endpackage : tfsr_pkg

// [hw/tfsr_port.sv]
// Status and read-data port toward the computer adaptor
`timescale 1ns/1ps
module tfsr_port
    import tfsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic selected,
    input wire logic cmd_strobe,
    input wire tfsr_pkg::tfsr_cmd_type cmd_code,
    input wire logic cmd_reverse,
    input wire logic ext_reject,
    input wire logic formatter_busy,
    input wire logic unit_busy,
    input wire logic unit_nine_track,
    input wire logic unit_has_track_attr,
    input wire logic unit_phase_encoded,
    input wire logic unit_dual_gap,
    input wire logic unit_high_speed,
    input wire logic unit_ready,
    input wire logic unit_rewinding,
    input wire logic unit_no_ring,
    input wire logic unit_at_bot,
    input wire logic pe_mode,
    input wire logic writing,
    input wire logic reading,
    input wire logic write_due,
    input wire logic xfer_ack,
    input wire logic pe_correctable,
    input wire logic pe_uncorrectable,
    input wire logic pe_bad_amble,
    input wire logic pe_skew,
    input wire logic pe_multi_dropout,
    input wire logic pe_vert_no_dropout,
    input wire logic nrz_lrc_error,
    input wire logic nrz_vrc_error,
    input wire logic file_mark_detect,
    input wire logic id_burst_detect,
    input wire logic char_ready,
    input wire logic [DATA_W-1:0] char_in,
    output logic command_refused_pulse,
    output logic command_refused_status,
    output logic command_accepted,
    output logic nine_track_unit_flag,
    output logic recording_method_flag,
    output logic head_type_flag,
    output logic speed_flag,
    output logic transfer_late_error,
    output logic check_error_flag,
    output logic corrected_error_flag,
    output logic file_mark_seen,
    output logic ready_flag,
    output logic rewind_pending_flag,
    output logic write_protected_flag,
    output logic at_load_point,
    output logic write_mode_flag,
    output logic read_mode_flag,
    output logic id_burst_seen,
    output logic read_char_strobe,
    output logic transfer_request_n,
    output logic [DATA_W-1:0] read_data
);
    import tfsr_pkg::*;

    tfsr_read_if rd ();

    tfsr_strobe_gen u_strobe (
        .clk(clk),
        .reset_n(reset_n),
        .char_ready(char_ready),
        .rd(rd.gen)
    );

    logic refuse_now;
    logic accept_now;
    logic clear_latches;
    logic ack_d_reg;
    logic ack_lead;
    logic req_pending_reg;
    logic late_reg;
    logic check_reg;
    logic corr_reg;
    logic fm_reg;
    logic id_reg;
    logic rew_reg;
    logic pe_err;
    logic nrz_err;

    // ------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------
    always_comb begin
        refuse_now = 1'b0;
        if ((formatter_busy || unit_busy) && cmd_code != TFSR_CMD_CLEAR) begin
            refuse_now = 1'b1; // R01
        end else if (cmd_reverse && unit_at_bot) begin
            refuse_now = 1'b1; // R02
        end else if (cmd_code == TFSR_CMD_WRITE && unit_no_ring) begin
            refuse_now = 1'b1; // R02
        end else if (ext_reject) begin
            refuse_now = 1'b1; // R02
        end
    end

    assign accept_now = cmd_strobe && selected && !refuse_now;
    // Latches drop on an accepted command or when deselected
    assign clear_latches = accept_now || !selected; // R23

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            command_refused_pulse <= IDLE;
            command_refused_status <= IDLE;
            command_accepted <= 1'b0;
        end else begin
            command_refused_pulse <= tfsr_lvl(cmd_strobe && selected && refuse_now); // R01
            command_accepted <= accept_now;
            if (cmd_strobe && selected && refuse_now) begin
                command_refused_status <= ACT; // R01
            end else if (clear_latches) begin
                command_refused_status <= IDLE;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transport attribute levels
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            nine_track_unit_flag <= IDLE;
            recording_method_flag <= ACT;
            head_type_flag <= ACT;
            speed_flag <= ACT;
            ready_flag <= IDLE;
            write_protected_flag <= IDLE;
            at_load_point <= IDLE;
        end else begin
            // Without the attribute the line stays released
            nine_track_unit_flag <= tfsr_lvl(selected && unit_has_track_attr
                                             && unit_nine_track); // R03
            recording_method_flag <= selected && unit_phase_encoded; // R04
            head_type_flag <= selected && unit_dual_gap; // R05
            speed_flag <= selected && unit_high_speed; // R06
            ready_flag <= tfsr_lvl(selected && unit_ready); // R12
            write_protected_flag <= tfsr_lvl(selected && unit_no_ring); // R14
            at_load_point <= tfsr_lvl(selected && unit_at_bot); // R15
        end
    end

    // ------------------------------------------------------------------
    // Mode indicators
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            write_mode_flag <= IDLE;
            read_mode_flag <= IDLE;
        end else begin
            write_mode_flag <= tfsr_lvl(selected && writing); // R16
            read_mode_flag <= tfsr_lvl(selected && reading); // R17
        end
    end

    // ------------------------------------------------------------------
    // Rewind status holds until the unit is ready again
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rew_reg <= 1'b0;
        end else if (unit_rewinding) begin
            rew_reg <= 1'b1; // R13
        end else if (unit_ready) begin
            rew_reg <= 1'b0; // R13
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rewind_pending_flag <= IDLE;
        end else begin
            rewind_pending_flag <= tfsr_lvl(selected && (rew_reg || unit_rewinding)); // R13
        end
    end

    // ------------------------------------------------------------------
    // Transfer request and timing error
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_d_reg <= 1'b0;
        end else begin
            ack_d_reg <= xfer_ack;
        end
    end

    assign ack_lead = xfer_ack && !ack_d_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_pending_reg <= 1'b0;
        end else if (rd.strobe_end || write_due) begin
            req_pending_reg <= 1'b1; // R21
        end else if (ack_lead) begin
            req_pending_reg <= 1'b0; // R24
        end
    end

    // A new due point with the request still open is a late transfer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            late_reg <= 1'b0;
        end else if (req_pending_reg && !ack_lead
                     && ((rd.strobe_start && reading) || write_due)) begin
            late_reg <= 1'b1; // R07
        end else if (clear_latches) begin
            late_reg <= 1'b0; // R23
        end
    end

    // ------------------------------------------------------------------
    // Error, file mark and identification latches
    // ------------------------------------------------------------------
    assign pe_err = pe_correctable || pe_uncorrectable || pe_bad_amble
                    || pe_skew || pe_multi_dropout; // R08
    assign nrz_err = nrz_lrc_error || nrz_vrc_error; // R10

    // Events on the same edge as a clear are kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            check_reg <= 1'b0;
            corr_reg <= 1'b0;
            fm_reg <= 1'b0;
            id_reg <= 1'b0;
        end else begin
            if (pe_mode ? pe_err : nrz_err) begin
                check_reg <= 1'b1; // R08 R10
            end else if (clear_latches) begin
                check_reg <= 1'b0;
            end
            if (pe_mode && pe_correctable) begin
                corr_reg <= 1'b1; // R19
            end else if (clear_latches) begin
                corr_reg <= 1'b0;
            end
            if (file_mark_detect) begin
                fm_reg <= 1'b1; // R11
            end else if (clear_latches) begin
                fm_reg <= 1'b0;
            end
            if (pe_mode && id_burst_detect && unit_at_bot) begin
                id_reg <= 1'b1; // R18
            end else if (clear_latches) begin
                id_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            transfer_late_error <= IDLE;
            check_error_flag <= IDLE;
            corrected_error_flag <= ACT;
            file_mark_seen <= IDLE;
            id_burst_seen <= IDLE;
        end else begin
            transfer_late_error <= tfsr_lvl(late_reg); // R07
            // Tag pulse only during the strobe of the suspect character
            check_error_flag <= tfsr_lvl(check_reg || (pe_mode && reading
                                && pe_vert_no_dropout && rd.strobe_active)); // R09
            // NRZ leaves the line at logic zero
            corrected_error_flag <= pe_mode ? tfsr_lvl(corr_reg) : ACT; // R19
            file_mark_seen <= tfsr_lvl(fm_reg); // R11
            id_burst_seen <= pe_mode ? tfsr_lvl(id_reg) : ACT; // R18
        end
    end

    // ------------------------------------------------------------------
    // Read data buffer and strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_data <= DATA_RESET;
        end else if (rd.strobe_start) begin
            read_data <= char_in; // R20
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_char_strobe <= IDLE;
            transfer_request_n <= IDLE;
        end else begin
            read_char_strobe <= tfsr_lvl(rd.strobe_active);
            // Request releases on the ack's leading edge unless a strobe end or write due point lands in the same cycle
            transfer_request_n <= tfsr_lvl(req_pending_reg
                                  && !(ack_lead && !rd.strobe_end
                                  && !write_due)); // R21 R24
        end
    end
endmodule : tfsr_port

// [hw/tfsr_read_if.sv]
// Link between read strobe generator and the top
`timescale 1ns/1ps
interface tfsr_read_if;
    logic strobe_active;
    logic strobe_end;
    logic strobe_start;
    modport gen (output strobe_active, output strobe_end, output strobe_start);
    modport use_side (input strobe_active, input strobe_end, input strobe_start);
endinterface : tfsr_read_if

// [hw/tfsr_strobe_gen.sv]
// Read strobe timing generator
`timescale 1ns/1ps
module tfsr_strobe_gen
    import tfsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic char_ready,
    tfsr_read_if.gen rd
);
    tfsr_rd_state_type state_reg;
    logic [STROBE_W-1:0] count_reg;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_reg <= TFSR_RD_IDLE;
            count_reg <= STROBE_ZERO;
        end else begin
            case (state_reg)
                TFSR_RD_IDLE: begin
                    if (char_ready) begin
                        state_reg <= TFSR_RD_LEAD;
                    end
                end
                TFSR_RD_LEAD: begin
                    state_reg <= TFSR_RD_STROBE;
                    count_reg <= STROBE_LEN;
                end
                TFSR_RD_STROBE: begin
                    if (count_reg == STROBE_ZERO + 4'h1) begin
                        state_reg <= TFSR_RD_IDLE;
                    end
                    count_reg <= count_reg - 4'h1;
                end
                default: state_reg <= TFSR_RD_IDLE;
            endcase
        end
    end

    // Data loads in LEAD, one cycle ahead of the strobe
    assign rd.strobe_start = (state_reg == TFSR_RD_LEAD); // R20
    assign rd.strobe_active = (state_reg == TFSR_RD_STROBE);
    assign rd.strobe_end = (state_reg == TFSR_RD_STROBE) && (count_reg == 4'h1);
endmodule : tfsr_strobe_gen

// [verification/tfsr_adaptor_model.sv]
// Behavioural computer adaptor facing the status and read port
`timescale 1ns/1ps
module tfsr_adaptor_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic transfer_request_n,
    input wire logic read_char_strobe,
    input wire logic slow,
    input wire logic [7:0] expect_chars,
    output logic xfer_ack,
    output logic over_length
);
    logic [4:0] wait_reg;
    logic [7:0] seen_reg;
    logic strobe_reg;
    // One-cycle ack; slow mode waits long enough to miss the next character
    always_ff @(posedge clk) begin
        if (!reset_n || transfer_request_n || xfer_ack) begin
            wait_reg <= 5'h00;
            xfer_ack <= 1'b0;
        end else if (wait_reg == (slow ? 5'h14 : 5'h01)) begin
            xfer_ack <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 5'h01;
        end
    end
    always_ff @(posedge clk) begin
        strobe_reg <= read_char_strobe;
        if (!reset_n) begin
            seen_reg <= 8'h00;
            over_length <= 1'b0;
        end else if (strobe_reg && !read_char_strobe) begin
            seen_reg <= seen_reg + 8'h01;
            over_length <= over_length || seen_reg >= expect_chars;
        end
    end
endmodule : tfsr_adaptor_model

// [verification/tfsr_port_properties.sv]
// Concurrent checks on the status and read port
`timescale 1ns/1ps
module tfsr_port_properties
    import tfsr_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic selected,
    input wire logic cmd_strobe,
    input wire tfsr_pkg::tfsr_cmd_type cmd_code,
    input wire logic ext_reject,
    input wire logic formatter_busy,
    input wire logic unit_ready,
    input wire logic unit_no_ring,
    input wire logic unit_phase_encoded,
    input wire logic xfer_ack,
    input wire logic write_due,
    input wire logic command_refused_pulse,
    input wire logic command_accepted,
    input wire logic recording_method_flag,
    input wire logic ready_flag,
    input wire logic write_protected_flag,
    input wire logic transfer_late_error,
    input wire logic read_char_strobe,
    input wire logic transfer_request_n,
    input wire logic [DATA_W-1:0] read_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_ready_level: assert property (
        $past(reset_n) && $past(selected) |-> ready_flag == !$past(unit_ready))
        else $error("ready status wrong");
    a_protect_level: assert property (
        $past(reset_n) && $past(selected) |-> write_protected_flag == !$past(unit_no_ring))
        else $error("write protect status wrong");
    a_method_level: assert property (
        $past(reset_n) && $past(selected) |-> recording_method_flag == $past(unit_phase_encoded))
        else $error("recording method wrong");
    a_busy_refuse: assert property (
        cmd_strobe && selected && formatter_busy && cmd_code != TFSR_CMD_CLEAR
        |=> !command_refused_pulse && !command_accepted)
        else $error("busy command not refused");
    a_ext_refuse: assert property (
        cmd_strobe && selected && ext_reject |=> !command_refused_pulse)
        else $error("external reject ignored");
    a_strobe_width: assert property (
        $fell(read_char_strobe) |-> !read_char_strobe [*4] ##1 read_char_strobe)
        else $error("read strobe width wrong");
    a_data_steady: assert property (
        !read_char_strobe |-> $stable(read_data))
        else $error("read data moved during strobe");
    a_request_set: assert property (
        $rose(read_char_strobe) |-> !transfer_request_n)
        else $error("no request at strobe end");
    a_ack_clears: assert property (
        $rose(xfer_ack) && !transfer_request_n && !write_due |=> transfer_request_n)
        else $error("ack did not clear request");
    a_late_holds: assert property (
        !transfer_late_error && $past(selected) && !$past(cmd_strobe) |=> !transfer_late_error)
        else $error("timing error dropped");
    c_late: cover property ($fell(transfer_late_error));
    c_refused: cover property ($fell(command_refused_pulse));
    c_ack: cover property ($rose(xfer_ack) && !transfer_request_n);
endmodule : tfsr_port_properties
bind tfsr_port tfsr_port_properties u_tfsr_port_properties (.*);

// [verification/tfsr_port_tb.sv]
// Self-checking bench for the status and read port
`timescale 1ns/1ps
module tfsr_port_tb;
    import tfsr_pkg::*;
    logic clk, write_due, pe_correctable, pe_uncorrectable, pe_bad_amble, pe_skew;
    logic pe_multi_dropout, nrz_lrc_error, nrz_vrc_error, file_mark_detect, id_burst_detect;
    logic unit_nine_track, unit_phase_encoded, unit_dual_gap, unit_high_speed, unit_ready;
    logic unit_rewinding, unit_no_ring, unit_at_bot, reading, writing, xfer_ack, over_length;
    logic reset_n = 1'b0, selected = 1'b1, cmd_strobe = 1'b0, cmd_reverse = 1'b0;
    logic ext_reject = 1'b0, formatter_busy = 1'b0, unit_busy = 1'b0, pe_mode = 1'b0;
    logic pe_vert_no_dropout = 1'b0, char_ready = 1'b0, slow = 1'b0;
    logic unit_has_track_attr = 1'b1;
    logic [7:0] expect_chars = 8'h05;
    logic [9:0] lv = 10'h000, ev = 10'h000;
    logic [DATA_W-1:0] char_in = 9'h000, read_data;
    tfsr_cmd_type cmd_code = TFSR_CMD_CLEAR;
    logic command_refused_pulse, command_refused_status, command_accepted;
    logic nine_track_unit_flag, recording_method_flag, head_type_flag, speed_flag;
    logic transfer_late_error, check_error_flag, corrected_error_flag, file_mark_seen;
    logic ready_flag, rewind_pending_flag, write_protected_flag, at_load_point;
    logic write_mode_flag, read_mode_flag, id_burst_seen, read_char_strobe;
    logic transfer_request_n, s1, s2;
    logic [DATA_W:0] notes[$];
    logic [DATA_W:0] note;
    int err_total = 0, n_compared = 0, cycles = 0;
    assign {file_mark_detect, id_burst_detect, pe_correctable, pe_uncorrectable, pe_bad_amble,
        pe_skew, pe_multi_dropout, nrz_lrc_error, nrz_vrc_error, write_due} = ev;
    assign {writing, reading, unit_at_bot, unit_no_ring, unit_rewinding, unit_ready,
        unit_high_speed, unit_dual_gap, unit_phase_encoded, unit_nine_track} = lv;
    tfsr_port u_tfsr_port (.*);
    tfsr_adaptor_model u_tfsr_adaptor_model (.clk(clk), .reset_n(reset_n),
        .transfer_request_n(transfer_request_n), .read_char_strobe(read_char_strobe),
        .slow(slow), .expect_chars(expect_chars), .xfer_ack(xfer_ack),
        .over_length(over_length));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
        input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc
    task automatic fire(input logic [9:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 10'h000;
    endtask : fire
    task automatic cmd(input tfsr_cmd_type c, input logic refused);
        @(posedge clk);
        cmd_strobe <= 1'b1;
        cmd_code <= c;
        @(posedge clk);
        cmd_strobe <= 1'b0;
        #1;
        chk(command_refused_pulse, !refused, "refusal pulse");
        chk(command_accepted, !refused, "accept pulse");
    endtask : cmd
    // Characters spaced 14 cycles: prompt acks make it, slow acks miss it
    task automatic send(input logic tag);
        logic [DATA_W-1:0] d;
        d = DATA_W'($urandom);
        @(posedge clk);
        char_ready <= 1'b1;
        char_in <= d;
        pe_vert_no_dropout <= tag;
        notes.push_back({tag, d});
        @(posedge clk);
        char_ready <= 1'b0;
        repeat (12) @(posedge clk);
        pe_vert_no_dropout <= 1'b0;
        #1;
    endtask : send
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    // Second strobe cycle: data and tag are settled by then
    always @(posedge clk) begin
        s1 <= read_char_strobe;
        s2 <= s1;
        if (reset_n && !read_char_strobe && !s1 && s2) begin
            if (notes.size() == 0) begin
                chk(1'b0, 1'b1, "unexpected strobe");
            end else begin
                note = notes.pop_front();
                chk(read_data, note[DATA_W-1:0], "read data");
                chk(check_error_flag, !note[DATA_W], "char tag");
            end
        end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            chk(1'b0, 1'b1, "timeout");
            summarize();
        end
    end
    initial begin
        void'($urandom(32'h155E));
        repeat (7) @(posedge clk);
        #1;
        chk(transfer_request_n, 1'b1, "reset request");
        chk(corrected_error_flag, 1'b0, "reset corrected");
        @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            lv <= 10'($urandom) & 10'h3DF;
            unit_has_track_attr <= i[0];
            wait_cyc(2);
            chk(nine_track_unit_flag, !(lv[0] && i[0]), "nine track");
            chk(recording_method_flag, lv[1], "method");
            chk(head_type_flag, lv[2], "head");
            chk(speed_flag, lv[3], "speed");
            chk(ready_flag, !lv[4], "ready");
            chk(write_protected_flag, !lv[6], "protect");
            chk(at_load_point, !lv[7], "load point");
            chk(read_mode_flag, !lv[8], "read mode");
            chk(write_mode_flag, !lv[9], "write mode");
        end
        @(posedge clk);
        lv <= 10'h010;
        formatter_busy <= 1'b1;
        for (int c = 0; c < 4; c++) cmd(tfsr_cmd_type'(c), c != 0);
        chk(command_refused_status, 1'b0, "refused status");
        @(posedge clk);
        formatter_busy <= 1'b0;
        unit_busy <= 1'b1;
        cmd(TFSR_CMD_WRITE, 1'b1);
        @(posedge clk);
        unit_busy <= 1'b0;
        cmd(TFSR_CMD_READ, 1'b0);
        wait_cyc(1);
        chk(command_refused_status, 1'b1, "status cleared");
        @(posedge clk);
        lv <= 10'h090;
        cmd_reverse <= 1'b1;
        cmd(TFSR_CMD_READ, 1'b1);
        @(posedge clk);
        lv <= 10'h050;
        cmd_reverse <= 1'b0;
        cmd(TFSR_CMD_WRITE, 1'b1);
        @(posedge clk);
        ext_reject <= 1'b1;
        cmd(TFSR_CMD_READ, 1'b1);
        @(posedge clk);
        ext_reject <= 1'b0;
        lv <= 10'h020;
        wait_cyc(2);
        chk(rewind_pending_flag, 1'b0, "rewinding");
        @(posedge clk);
        lv <= 10'h000;
        wait_cyc(3);
        chk(rewind_pending_flag, 1'b0, "not ready after rewind");
        @(posedge clk);
        lv <= 10'h010;
        wait_cyc(2);
        chk(rewind_pending_flag, 1'b1, "rewind done");
        fire(10'h200);
        wait_cyc(6);
        chk(file_mark_seen, 1'b0, "file mark");
        @(posedge clk);
        pe_mode <= 1'b1;
        lv <= 10'h090;
        fire(10'h100);
        wait_cyc(2);
        chk(id_burst_seen, 1'b0, "id burst");
        @(posedge clk);
        selected <= 1'b0;
        wait_cyc(2);
        chk(file_mark_seen, 1'b1, "deselect clears");
        @(posedge clk);
        selected <= 1'b1;
        for (int b = 1; b < 8; b++) begin
            @(posedge clk);
            pe_mode <= (b > 2);
            fire(10'(1 << b));
            wait_cyc(2);
            chk(check_error_flag, 1'b0, "check error");
            chk(corrected_error_flag, b > 2 && b != 7, "corrected");
            cmd(TFSR_CMD_CLEAR, 1'b0);
            wait_cyc(1);
            chk(check_error_flag, 1'b1, "check cleared");
        end
        @(posedge clk);
        lv <= 10'h110;
        pe_mode <= 1'b1;
        for (int i = 0; i < 6; i++) send(i == 3);
        chk(transfer_late_error, 1'b1, "no late error");
        chk(over_length, 1'b1, "over length");
        @(posedge clk);
        slow <= 1'b1;
        send(1'b0);
        send(1'b0);
        chk(transfer_late_error, 1'b0, "read late");
        cmd(TFSR_CMD_CLEAR, 1'b0);
        wait_cyc(1);
        chk(transfer_late_error, 1'b1, "late cleared");
        fire(10'h001);
        repeat (4) @(posedge clk);
        fire(10'h001);
        wait_cyc(2);
        chk(transfer_late_error, 1'b0, "write late");
        wait_cyc(30);
        summarize();
    end
endmodule : tfsr_port_tb
